// *** verilog/tgrf_defs.svh ***
`ifndef TGRF_DEFS_SVH
`define TGRF_DEFS_SVH
// Register geometry
`define TGRF_REG_BITS      256
`define TGRF_REG_BYTES     32
`define TGRF_REGS_PER_THR  128
`define TGRF_PHYS_REGS     640
`define TGRF_THREADS       5
// Dispatch masks for the four-wide paired mode
`define TGRF_DMASK_TWO     16'h00FF
`define TGRF_DMASK_ONE     16'h000F
// Register file selector encodings
`define TGRF_RF_GENERAL    2'h0
`define TGRF_RF_MESSAGE    2'h1
`define TGRF_RF_ARCH       2'h2
`define TGRF_RF_IMM        2'h3
`endif

// *** verilog/tgrf_pkg.sv ***
package tgrf_pkg;
   typedef enum logic [1:0] {
      TGRF_MODE_S4X2,
      TGRF_MODE_S8,
      TGRF_MODE_S16
   } tgrf_mode_t;
   typedef enum logic [1:0] {
      TGRF_RF_GENERAL,
      TGRF_RF_MESSAGE,
      TGRF_RF_ARCH,
      TGRF_RF_IMM
   } tgrf_rf_t;
endpackage

// *** verilog/tgrf_core.sv ***
// Behaviour
// - Paired four-wide launch with two flows gives dispatch mask 0x00FF.
// - Paired four-wide launch with one flow gives dispatch mask 0x000F.
// - Execution mask starts from dispatch mask; masked elements keep contents.
// - Paired four-wide sources may start at any 16-byte boundary.
// - Sixteen-flow dispatch mask is four 4-bit subspan groups.
// - Vertical stride zero re-reads the same source row every row.
// - Compressed sixteen-wide runs as two halves; second uses next register, upper mask.
// - Operand file selects general, message, architecture or immediate.
// - Message registers are write only, never read by instructions.
// - Each thread has a private register context.
// - Dispatch may load payload; other registers stay uninitialized.
// - Register space is allocated to a thread at dispatch.
// - Zero-based logical indices translate to physical rows per thread table.
// - 16-byte granular region reads; byte granular writes with byte write enables.
// - Direct addressing, and indirect as address register plus immediate.
// - 256-bit registers, 128 per thread, 640 in the unit pool.
`timescale 1ns/1ps
`include "tgrf_defs.svh"
module tgrf_core #(
   parameter int THREADS = `TGRF_THREADS,
   parameter int PHYS    = `TGRF_PHYS_REGS,
   parameter int PER_THR = `TGRF_REGS_PER_THR
) (
   input  wire logic                     sys_clk_i,
   input  wire logic                     srst_i,
   // Dispatch
   input  wire logic                     disp_valid_i,
   input  wire logic [2:0]               disp_thread_i,
   input  wire tgrf_pkg::tgrf_mode_t     disp_mode_i,
   input  wire logic                     disp_two_flows_i,
   input  wire logic [3:0]               disp_subspan_i,
   output logic                          disp_ok_o,
   output logic                          thr_alloc_o [THREADS],
   output logic [15:0]                   thr_dmask_o [THREADS],
   // Payload load at dispatch
   input  wire logic                     pay_we_i,
   input  wire logic [6:0]               pay_reg_i,
   input  wire logic [255:0]             pay_data_i,
   // Retire
   input  wire logic                     ret_valid_i,
   input  wire logic [2:0]               ret_thread_i,
   // Execution mask update from flow control
   input  wire logic                     emask_we_i,
   input  wire logic [15:0]              emask_i,
   // Source read
   input  wire logic                     rd_valid_i,
   input  wire logic [2:0]               rd_thread_i,
   input  wire tgrf_pkg::tgrf_rf_t       rd_file_i,
   input  wire logic                     rd_indirect_i,
   input  wire logic [15:0]              addr_reg_zero_i,
   input  wire logic [12:0]              rd_byte_addr_i,
   input  wire logic                     rd_vstride_zero_i,
   input  wire logic                     rd_second_half_flag_i,
   input  wire logic [255:0]             rd_imm_i,
   output logic [255:0]                  rd_lo_o,
   output logic [255:0]                  rd_hi_o,
   output logic                          rd_valid_o,
   output logic                          rd_err_o,
   // Destination write
   input  wire logic                     wr_valid_i,
   input  wire logic [2:0]               wr_thread_i,
   input  wire tgrf_pkg::tgrf_rf_t       wr_file_i,
   input  wire logic                     wr_indirect_i,
   input  wire logic [12:0]              wr_byte_addr_i,
   input  wire logic                     wr_second_half_flag_i,
   input  wire logic                     wr_nomask_i,
   input  wire logic [255:0]             wr_data_i,
   input  wire logic [31:0]              wr_byte_en_i,
   input  wire logic [7:0]               wr_chan_en_i,
   output logic                          wr_err_o,
   output logic                          msg_we_o,
   output logic [4:0]                    msg_reg_o,
   output logic [255:0]                  msg_data_o,
   output logic [31:0]                   msg_byte_en_o
);
   localparam int PW = $clog2(PHYS);

   // Limitation: slices are fixed, so a thread cannot borrow rows another slot leaves idle
   // Physical pool; contents have no reset value on purpose
   logic [255:0]  ram [PHYS];
   logic [PW-1:0] base_r  [THREADS];
   logic          alloc_r [THREADS];
   logic [15:0]   dmask_r [THREADS];
   logic [15:0]   emask_r [THREADS];
   logic [2:0]    pay_thr_r;

   // Logical register to physical row; wraps inside the thread's slice
   function automatic logic [PW-1:0] tgrf_xlate(input logic [PW-1:0] base, input logic [6:0] lreg);
      tgrf_xlate = base + PW'(lreg);
   endfunction

   // Byte address, direct or address register plus immediate
   function automatic logic [12:0] tgrf_eaddr(input logic ind, input logic [15:0] ar, input logic [12:0] imm);
      tgrf_eaddr = ind ? (ar[12:0] + imm) : imm;
   endfunction

   // Dispatch mask from mode and flow availability
   function automatic logic [15:0] tgrf_dmask(input tgrf_pkg::tgrf_mode_t m, input logic two,
                                              input logic [3:0] ss);
      logic [15:0] r;
      r = 16'h0000;
      case (m)
         tgrf_pkg::TGRF_MODE_S4X2: r = two ? `TGRF_DMASK_TWO : `TGRF_DMASK_ONE;
         tgrf_pkg::TGRF_MODE_S8:   r = {8'h00, {4{ss[1]}}, {4{ss[0]}}};
         tgrf_pkg::TGRF_MODE_S16:  r = {{4{ss[3]}}, {4{ss[2]}}, {4{ss[1]}}, {4{ss[0]}}};
         default:                  r = 16'h0000;
      endcase
      return r;
   endfunction

   // Slot in range and holding a live thread; anything else never reaches the RAM
   function automatic logic tgrf_live(input logic [2:0] thr, input logic alloc);
      tgrf_live = (int'(thr) < THREADS) && alloc;
   endfunction

   // Grant is combinational so the dispatcher learns the answer in the request cycle
   // Free slot check on the requested slot: thread slot t owns rows t*PER_THR onward
   logic disp_ok;
   always_comb begin
      disp_ok = disp_valid_i && (int'(disp_thread_i) < THREADS)
                && ((int'(disp_thread_i) + 1) * PER_THR <= PHYS) && !alloc_r[disp_thread_i];
   end
   assign disp_ok_o = disp_ok;

   // Allocation flags: a launch claims the slot, a retire frees it
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         for (int t = 0; t < THREADS; t++) begin
            alloc_r[t] <= 1'b0;
         end
      end else begin
         if (ret_valid_i && int'(ret_thread_i) < THREADS) begin
            alloc_r[ret_thread_i] <= 1'b0;
         end
         if (disp_ok) begin
            alloc_r[disp_thread_i] <= 1'b1;
         end
      end
   end

   // Base row per slot; fixed slices keep one thread out of another's rows
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         for (int t = 0; t < THREADS; t++) begin
            base_r[t] <= '0;
         end
      end else if (disp_ok) begin
         base_r[disp_thread_i] <= PW'(int'(disp_thread_i) * PER_THR);
      end
   end

   // Dispatch mask stays fixed for the life of the thread
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         for (int t = 0; t < THREADS; t++) begin
            dmask_r[t] <= 16'h0000;
         end
      end else if (disp_ok) begin
         dmask_r[disp_thread_i] <= tgrf_dmask(disp_mode_i, disp_two_flows_i, disp_subspan_i);
      end
   end

   // Execution mask: seeded at launch, never wider than the dispatch mask afterwards
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         for (int t = 0; t < THREADS; t++) begin
            emask_r[t] <= 16'h0000;
         end
      end else begin
         if (emask_we_i && int'(wr_thread_i) < THREADS) begin
            emask_r[wr_thread_i] <= emask_i & dmask_r[wr_thread_i];
         end
         if (disp_ok) begin
            emask_r[disp_thread_i] <= tgrf_dmask(disp_mode_i, disp_two_flows_i, disp_subspan_i);
         end
      end
   end

   // Payload goes to the most recent earlier launch while its slot is still allocated
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pay_thr_r <= 3'h0;
      end else if (disp_ok) begin
         pay_thr_r <= disp_thread_i;
      end
   end

   always_comb begin
      for (int t = 0; t < THREADS; t++) begin
         thr_alloc_o[t] = alloc_r[t];
         thr_dmask_o[t] = dmask_r[t];
      end
   end

   // Read path: region start on 16-byte boundary, spans two adjacent registers
   logic [12:0]   rd_ea;
   logic [6:0]    rd_lreg;
   logic          rd_ok;
   always_comb begin
      rd_ea   = tgrf_eaddr(rd_indirect_i, addr_reg_zero_i, rd_byte_addr_i);
      rd_lreg = rd_ea[11:5] + {6'h00, rd_second_half_flag_i & ~rd_vstride_zero_i};
      rd_ok   = rd_valid_i && tgrf_live(rd_thread_i, alloc_r[rd_thread_i]);
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rd_lo_o    <= '0;
         rd_hi_o    <= '0;
         rd_valid_o <= 1'b0;
         rd_err_o   <= 1'b0;
      end else begin
         rd_valid_o <= rd_valid_i;
         rd_err_o   <= 1'b0;
         if (rd_valid_i) begin
            case (rd_file_i)
               tgrf_pkg::TGRF_RF_GENERAL: begin
                  if (rd_ok) begin
                     // 16-byte granule shift within the register pair
                     rd_lo_o <= 256'({ram[tgrf_xlate(base_r[rd_thread_i], rd_lreg + 7'h01)],
                                      ram[tgrf_xlate(base_r[rd_thread_i], rd_lreg)]} >> (rd_ea[4] ? 128 : 0));
                     rd_hi_o <= ram[tgrf_xlate(base_r[rd_thread_i], rd_lreg + 7'h01)];
                  end else begin
                     rd_err_o <= 1'b1;
                  end
               end
               // Immediates have no storage; the data rides with the request
               tgrf_pkg::TGRF_RF_IMM: begin
                  rd_lo_o <= rd_imm_i;
                  rd_hi_o <= '0;
               end
               tgrf_pkg::TGRF_RF_MESSAGE: begin
                  rd_lo_o  <= '0;
                  rd_hi_o  <= '0;
                  rd_err_o <= 1'b1;
               end
               // Architecture file lives outside this block; reads see zero
               default: begin
                  rd_lo_o <= '0;
                  rd_hi_o <= '0;
               end
            endcase
         end
      end
   end

   // Write enables: channel from execution mask, half from flag, bytes from region
   logic [12:0] wr_ea;
   logic [6:0]  wr_lreg;
   logic [7:0]  wr_emask;
   logic [31:0] wr_be;
   logic        wr_ok;
   always_comb begin
      wr_ea    = tgrf_eaddr(wr_indirect_i, addr_reg_zero_i, wr_byte_addr_i);
      wr_lreg  = wr_ea[11:5] + {6'h00, wr_second_half_flag_i};
      wr_emask = wr_nomask_i ? 8'hFF :
                 (wr_second_half_flag_i ? emask_r[wr_thread_i][15:8] : emask_r[wr_thread_i][7:0]);
      wr_be    = 32'h0000_0000;
      for (int c = 0; c < 8; c++) begin
         wr_be[c*4 +: 4] = {4{wr_emask[c] & wr_chan_en_i[c]}};
      end
      wr_be    = wr_be & wr_byte_en_i;
      wr_ok    = wr_valid_i && tgrf_live(wr_thread_i, alloc_r[wr_thread_i]);
   end

   // Register RAM: payload port and instruction write port; masked bytes hold
   always_ff @(posedge sys_clk_i) begin
      if (pay_we_i && alloc_r[pay_thr_r]) begin
         ram[tgrf_xlate(base_r[pay_thr_r], pay_reg_i)] <= pay_data_i;
      end
      if (wr_ok && wr_file_i == tgrf_pkg::TGRF_RF_GENERAL) begin
         for (int b = 0; b < 32; b++) begin
            if (wr_be[b]) begin
               ram[tgrf_xlate(base_r[wr_thread_i], wr_lreg)][b*8 +: 8] <= wr_data_i[b*8 +: 8];
            end
         end
      end
   end

   // Message file writes leave the block as a strobe with data
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         msg_we_o      <= 1'b0;
         msg_reg_o     <= 5'h00;
         msg_data_o    <= '0;
         msg_byte_en_o <= 32'h0000_0000;
         wr_err_o      <= 1'b0;
      end else begin
         msg_we_o <= wr_ok && wr_file_i == tgrf_pkg::TGRF_RF_MESSAGE;
         wr_err_o <= wr_valid_i && !wr_ok;
         if (wr_ok && wr_file_i == tgrf_pkg::TGRF_RF_MESSAGE) begin
            msg_reg_o     <= wr_lreg[4:0];
            msg_data_o    <= wr_data_i;
            msg_byte_en_o <= wr_be;
         end
      end
   end
endmodule

// *** sim/tgrf_core_sva.sv ***
`timescale 1ns/1ps
module tgrf_core_sva #(
   parameter int THREADS = 5
) (
   input wire logic                 sys_clk_i,
   input wire logic                 srst_i,
   input wire logic                 disp_valid_i,
   input wire logic [2:0]           disp_thread_i,
   input wire tgrf_pkg::tgrf_mode_t disp_mode_i,
   input wire logic                 disp_two_flows_i,
   input wire logic [3:0]           disp_subspan_i,
   input wire logic                 disp_ok_o,
   input wire logic                 thr_alloc_o [THREADS],
   input wire logic [15:0]          thr_dmask_o [THREADS],
   input wire logic                 rd_valid_i,
   input wire tgrf_pkg::tgrf_rf_t   rd_file_i,
   input wire logic                 rd_valid_o,
   input wire logic                 rd_err_o,
   input wire logic                 wr_valid_i,
   input wire tgrf_pkg::tgrf_rf_t   wr_file_i,
   input wire logic                 msg_we_o
);
   logic [2:0] t_r;
   logic [3:0] ss_r;
   wire        take = disp_valid_i && disp_ok_o;
   default clocking dc @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   // Launch fields kept so the mask can be judged one edge later
   always_ff @(posedge sys_clk_i) begin
      t_r  <= disp_thread_i;
      ss_r <= disp_subspan_i;
   end
   // Masks and allocation land on the edge that takes the launch
   two_flow_a: assert property (take && disp_mode_i == tgrf_pkg::TGRF_MODE_S4X2 && disp_two_flows_i
      |=> thr_dmask_o[t_r] == 16'h00FF) else $error("two-flow mask wrong");
   one_flow_a: assert property (take && disp_mode_i == tgrf_pkg::TGRF_MODE_S4X2 && !disp_two_flows_i
      |=> thr_dmask_o[t_r] == 16'h000F) else $error("one-flow mask wrong");
   subspan_mask_a: assert property (take && disp_mode_i == tgrf_pkg::TGRF_MODE_S16 |=>
      thr_dmask_o[t_r] == {{4{ss_r[3]}}, {4{ss_r[2]}}, {4{ss_r[1]}}, {4{ss_r[0]}}}) else $error("group mask wrong");
   alloc_set_a: assert property (take |=> thr_alloc_o[t_r]) else $error("slot not allocated");
   busy_refuse_a: assert property (disp_valid_i && int'(disp_thread_i) < THREADS
      && thr_alloc_o[disp_thread_i] |-> !disp_ok_o) else $error("busy slot taken");
   // Read answers repeat the request valid, one edge after the request
   rd_answer_a: assert property (rd_valid_o == $past(rd_valid_i)) else $error("read answer late");
   msg_read_err_a: assert property (rd_valid_i && rd_file_i == tgrf_pkg::TGRF_RF_MESSAGE
      |=> rd_err_o && rd_valid_o) else $error("message read not refused");
   msg_strobe_a: assert property (msg_we_o |->
      $past(wr_valid_i && wr_file_i == tgrf_pkg::TGRF_RF_MESSAGE)) else $error("stray message strobe");
   cover property (take ##1 take);
   cover property (take && disp_mode_i == tgrf_pkg::TGRF_MODE_S8);
   cover property (msg_we_o);
   cover property (rd_err_o);
endmodule
bind tgrf_core tgrf_core_sva #(.THREADS(THREADS)) u_sva (.sys_clk_i, .srst_i, .disp_valid_i, .disp_thread_i,
   .disp_mode_i, .disp_two_flows_i, .disp_subspan_i, .disp_ok_o, .thr_alloc_o, .thr_dmask_o, .rd_valid_i,
   .rd_file_i, .rd_valid_o, .rd_err_o, .wr_valid_i, .wr_file_i, .msg_we_o);

// *** sim/tgrf_disp_model.sv ***
`timescale 1ns/1ps
module tgrf_disp_model (
   input  wire logic            sys_clk_i,
   input  wire logic            disp_ok_i,
   output logic                 disp_valid_o,
   output logic [2:0]           disp_thread_o,
   output tgrf_pkg::tgrf_mode_t disp_mode_o,
   output logic                 disp_two_flows_o,
   output logic [3:0]           disp_subspan_o
);
   // Quiet dispatcher until the first launch
   initial begin
      disp_valid_o = 1'b0;
      disp_thread_o = 3'h0;
      disp_mode_o = tgrf_pkg::TGRF_MODE_S4X2;
      disp_two_flows_o = 1'b0;
      disp_subspan_o = 4'h0;
   end
   // Invalid subspans are passed as clear bits
   task automatic launch(input logic [2:0] t, input tgrf_pkg::tgrf_mode_t m, input logic two,
                         input logic [3:0] ss, output logic ok);
      @(posedge sys_clk_i) #1;
      disp_valid_o = 1'b1;
      disp_thread_o = t;
      disp_mode_o = m;
      disp_two_flows_o = two;
      disp_subspan_o = ss;
      #1 ok = disp_ok_i;
      @(posedge sys_clk_i) #1;
      // Released thread, flow and subspan lines inverted so stale values cannot pass
      disp_valid_o = 1'b0;
      disp_thread_o = ~t;
      disp_two_flows_o = ~two;
      disp_subspan_o = ~ss;
   endtask
endmodule

// *** sim/tgrf_core_tb.sv ***
`timescale 1ns/1ps
module tgrf_core_tb;
   logic       sys_clk_i = 1'b0, srst_i = 1'b1, pay_we_i = 1'b0, ret_valid_i = 1'b0, emask_we_i = 1'b0, ok;
   logic       rd_valid_i = 1'b0, rd_indirect_i = 1'b0, rd_vstride_zero_i = 1'b0, rd_second_half_flag_i = 1'b0;
   logic       wr_valid_i = 1'b0, wr_indirect_i = 1'b0, wr_second_half_flag_i = 1'b0, wr_nomask_i = 1'b0;
   logic       disp_valid_i, disp_two_flows_i, disp_ok_o, rd_valid_o, rd_err_o, wr_err_o, msg_we_o;
   logic [2:0] disp_thread_i, ret_thread_i = 3'h0, rd_thread_i = 3'h0, wr_thread_i = 3'h0;
   logic [3:0] disp_subspan_i;
   logic [4:0] msg_reg_o;
   logic [6:0] pay_reg_i = 7'h00;
   logic [7:0] wr_chan_en_i = 8'hFF;
   logic [12:0] rd_byte_addr_i = 13'h0000, wr_byte_addr_i = 13'h0000;
   logic [15:0] emask_i = 16'h0000, addr_reg_zero_i = 16'h0000, thr_dmask_o [5];
   logic [31:0] wr_byte_en_i = 32'hFFFFFFFF, msg_byte_en_o;
   logic [255:0] pay_data_i = 256'h0, rd_imm_i = 256'h0, wr_data_i = 256'h0, rd_lo_o, rd_hi_o, msg_data_o, d0, d1;
   logic       thr_alloc_o [5];
   tgrf_pkg::tgrf_mode_t disp_mode_i;
   tgrf_pkg::tgrf_rf_t rd_file_i = tgrf_pkg::TGRF_RF_GENERAL, wr_file_i = tgrf_pkg::TGRF_RF_GENERAL;
   int         bad_count = 0, compares = 0, cyc = 0;
   tgrf_core dut (.*);
   tgrf_disp_model dp (.sys_clk_i, .disp_ok_i(disp_ok_o), .disp_valid_o(disp_valid_i), .disp_thread_o(disp_thread_i),
      .disp_mode_o(disp_mode_i), .disp_two_flows_o(disp_two_flows_i), .disp_subspan_o(disp_subspan_i));
   // 250 MHz clock
   initial forever #2 sys_clk_i = ~sys_clk_i;
   // Hang guard well above the expected run length
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 1500) begin
         bad_count++;
         final_report;
      end
   end
   task automatic chk(input logic [255:0] s, input logic [255:0] e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One-cycle requests; answers are settled when these return
   task automatic wr(input logic [2:0] t, input tgrf_pkg::tgrf_rf_t f, input logic [12:0] a, input logic [255:0] d,
                     input logic nm, input logic [7:0] ch);
      @(posedge sys_clk_i) #1 wr_valid_i = 1'b1;
      {wr_thread_i, wr_byte_addr_i, wr_data_i, wr_nomask_i, wr_chan_en_i} = {t, a, d, nm, ch};
      wr_file_i = f;
      @(posedge sys_clk_i) #1 wr_valid_i = 1'b0;
      wr_data_i = ~d;
   endtask
   task automatic rd(input logic [2:0] t, input tgrf_pkg::tgrf_rf_t f, input logic [12:0] a);
      @(posedge sys_clk_i) #1 rd_valid_i = 1'b1;
      {rd_thread_i, rd_byte_addr_i} = {t, a};
      rd_file_i = f;
      @(posedge sys_clk_i) #1 rd_valid_i = 1'b0;
   endtask
   task automatic final_report;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      for (int i = 0; i < 32; i++) d0[8*i +: 8] = 8'(i);
      d1 = ~d0;
      repeat (8) @(posedge sys_clk_i);
      #1 srst_i = 1'b0;
      dp.launch(3'h0, tgrf_pkg::TGRF_MODE_S4X2, 1'b1, 4'h0, ok);
      chk(ok, 1'b1);
      chk(thr_dmask_o[0], 16'h00FF);
      dp.launch(3'h1, tgrf_pkg::TGRF_MODE_S4X2, 1'b0, 4'h0, ok);
      chk(thr_dmask_o[1], 16'h000F);
      dp.launch(3'h2, tgrf_pkg::TGRF_MODE_S16, 1'b0, 4'hA, ok);
      chk(thr_dmask_o[2], 16'hF0F0);
      chk(thr_alloc_o[2], 1'b1);
      @(posedge sys_clk_i) #1 pay_we_i = 1'b1;
      {pay_reg_i, pay_data_i} = {7'h01, d1};
      @(posedge sys_clk_i) #1 pay_we_i = 1'b0;
      rd(3'h2, tgrf_pkg::TGRF_RF_GENERAL, 13'h0020);
      chk(rd_lo_o, d1);
      chk(rd_valid_o, 1'b1);
      // Second half of a compressed write: next register, upper mask groups only
      wr(3'h2, tgrf_pkg::TGRF_RF_GENERAL, 13'h0060, d1, 1'b1, 8'hFF);
      wr_second_half_flag_i = 1'b1;
      wr(3'h2, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040, d0, 1'b0, 8'hFF);
      wr_second_half_flag_i = 1'b0;
      rd(3'h2, tgrf_pkg::TGRF_RF_GENERAL, 13'h0060);
      chk(rd_lo_o, {d0[255:128], d1[127:0]});
      dp.launch(3'h0, tgrf_pkg::TGRF_MODE_S8, 1'b0, 4'h3, ok);
      chk(ok, 1'b0);
      // Retire frees the slot for a fresh eight-wide launch
      @(posedge sys_clk_i) #1 {ret_valid_i, ret_thread_i} = {1'b1, 3'h2};
      @(posedge sys_clk_i) #1 ret_valid_i = 1'b0;
      chk(thr_alloc_o[2], 1'b0);
      dp.launch(3'h2, tgrf_pkg::TGRF_MODE_S8, 1'b0, 4'h2, ok);
      chk({ok, thr_dmask_o[2]}, {1'b1, 16'h00F0});
      wr(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040, d0, 1'b1, 8'hFF);
      wr(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0060, d1, 1'b1, 8'hFF);
      rd(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040);
      chk(rd_lo_o, d0);
      chk(rd_hi_o, d1);
      rd(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0050);
      chk(rd_lo_o, {d1[127:0], d0[255:128]});
      rd_second_half_flag_i = 1'b1;
      rd(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040);
      chk(rd_lo_o[127:0], d1[127:0]);
      rd_vstride_zero_i = 1'b1;
      rd(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040);
      chk(rd_lo_o[127:0], d0[127:0]);
      {rd_vstride_zero_i, rd_second_half_flag_i, wr_byte_en_i} = {2'b00, 32'h0000FFFF};
      wr(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0060, 256'h0, 1'b1, 8'hFF);
      wr_byte_en_i = 32'hFFFFFFFF;
      rd(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0060);
      chk(rd_lo_o, {d1[255:128], 128'h0});
      // Thread 1 runs with one flow: only channels 0..3 may change
      wr(3'h1, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040, d0, 1'b1, 8'hFF);
      wr(3'h1, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040, d1, 1'b0, 8'hFF);
      rd(3'h1, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040);
      chk(rd_lo_o, {d0[255:128], d1[127:0]});
      @(posedge sys_clk_i) #1 emask_we_i = 1'b1;
      {emask_i, wr_thread_i} = {16'h0003, 3'h0};
      @(posedge sys_clk_i) #1 emask_we_i = 1'b0;
      wr(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040, 256'h0, 1'b0, 8'hFE);
      rd(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040);
      chk(rd_lo_o, {d0[255:64], 32'h0, d0[31:0]});
      wr(3'h0, tgrf_pkg::TGRF_RF_MESSAGE, 13'h00A0, d1, 1'b1, 8'hFF);
      chk({msg_we_o, msg_reg_o}, {1'b1, 5'h05});
      chk(msg_data_o, d1);
      chk(msg_byte_en_o, 32'hFFFFFFFF);
      rd(3'h0, tgrf_pkg::TGRF_RF_MESSAGE, 13'h00A0);
      chk(rd_err_o, 1'b1);
      // Immediate data comes back as given; the outside file reads as zero
      rd_imm_i = d1;
      rd(3'h0, tgrf_pkg::TGRF_RF_IMM, 13'h0000);
      chk(rd_lo_o, d1);
      rd(3'h0, tgrf_pkg::TGRF_RF_ARCH, 13'h0000);
      chk(rd_lo_o, 256'h0);
      chk(rd_err_o, 1'b0);
      wr(3'h3, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040, d0, 1'b1, 8'hFF);
      chk(wr_err_o, 1'b1);
      // Indirect access adds the address register; its bit 12 is dropped, so the write stays in thread 0's rows
      {rd_indirect_i, addr_reg_zero_i} = {1'b1, 16'h0020};
      rd(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0020);
      chk(rd_lo_o, {d0[255:64], 32'h0, d0[31:0]});
      {rd_indirect_i, wr_indirect_i, addr_reg_zero_i} = {2'b01, 16'h1000};
      wr(3'h0, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040, d1, 1'b1, 8'hFF);
      wr_indirect_i = 1'b0;
      rd(3'h1, tgrf_pkg::TGRF_RF_GENERAL, 13'h0040);
      chk(rd_lo_o, {d0[255:128], d1[127:0]});
      final_report;
   end
endmodule
